/* usb_app_fifo_port.sv */
// Purpose: Application parallel port and FIFO RAM sequencing
// Assumes: External RAMs read asynchronously from the shared read pointer
// Notes: One access per strobe falling edge; read data one cycle later, packet-ready and unmapped reads on the access edge itself
`timescale 1ns/100ps
module usb_app_fifo_port (
  // Clocking and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sysReset,
  // Host parallel port
  input wire logic wrRdSel,
  input wire logic [7:0] registerSelectBus,
  input wire logic [7:0] hostWriteBus,
  input wire logic dataStrobeN,
  output logic [7:0] hostReadBus,
  // Mode inputs
  input wire logic fullSpeed,
  input wire logic extPllSelIn,
  input wire logic testMode,
  // Status toward host
  output logic [3:0] pktRdy,
  output logic setupRdy,
  output logic isoErr,
  output logic validSof,
  output logic usbReset,
  output logic extPllActive,
  output logic loopbackActive,
  // Serial engine side
  input wire usb_app_pkg::rx_byte_t rxIn,
  input wire usb_app_pkg::tx_req_t txReq,
  input wire logic sofDetect,
  input wire logic usbResetIn,
  output logic [7:0] txByte,
  output logic txByteValid,
  // Transmit RAMs
  input wire logic [7:0] trxOutData,
  output logic [7:0] trxInData,
  output logic [2:0] trxSel,
  output logic [8:0] trxWrPtr,
  output logic [8:0] trxRdPtr,
  output logic [6:0] trxWrb,
  // Receive RAMs
  input wire logic [7:0] rcvOutData,
  output logic [7:0] rcvInData,
  output logic [2:0] rcvSel,
  output logic [8:0] rcvWrPtr,
  output logic [8:0] rcvRdPtr,
  output logic [6:0] rcvWrb
);

  // Returns {hit, index} for a seven-entry FIFO window
  function automatic logic [3:0] fifoHit(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    fifoHit = {(a >= base) && (off < usb_app_pkg::FIFO_NUM8), off[2:0]};
  endfunction

  logic rst;
  logic strobePrev_r;
  logic access;
  logic [3:0] txHit;
  logic [3:0] rxHit;
  logic regfHit;
  logic [7:0] regfData;
  usb_app_pkg::rd_kind_t rdKind_r;
  logic [2:0] rdFifo_r;
  logic txLast_r;
  logic [2:0] txFifo_r;
  logic txPend_r;
  usb_app_pkg::rx_byte_t rxSrc;
  logic [8:0] txWp_r [usb_app_pkg::FIFO_NUM];
  logic [8:0] txRp_r [usb_app_pkg::FIFO_NUM];
  logic [8:0] rxWp_r [usb_app_pkg::FIFO_NUM];
  logic [8:0] rxRp_r [usb_app_pkg::FIFO_NUM];
  logic [3:0] setupCnt_r;
  logic [8:0] sofCnt_r;
  logic hostFifoPop;
  logic [7:0] statusByte;

  assign rst = !nrst || sysReset;

  // One access per strobe fall; host keeps bus steady while low
  assign access = !dataStrobeN && strobePrev_r;
  assign txHit = fifoHit(registerSelectBus, usb_app_pkg::TX_BASE);
  assign rxHit = fifoHit(registerSelectBus, usb_app_pkg::RX_BASE);
  assign regfHit = !registerSelectBus[7];
  assign hostFifoPop = (rdKind_r == usb_app_pkg::RD_FIFO);

  // Loopback replaces the serial receive stream with transmit reads
  always_comb begin
    rxSrc = rxIn;
    if (loopbackActive) begin
      rxSrc.valid = txPend_r;
      rxSrc.fifo = txFifo_r;
      rxSrc.data = trxOutData;
      rxSrc.last = txLast_r;
      rxSrc.setup = 1'b0;
      rxSrc.iso = 1'b0;
      rxSrc.data1 = 1'b0;
    end
  end

  always_comb begin
    statusByte = usb_app_pkg::DATA_RST;
    statusByte[usb_app_pkg::ST_SETUP] = setupRdy;
    statusByte[usb_app_pkg::ST_ISO] = isoErr;
    statusByte[usb_app_pkg::ST_USBRST] = usbReset;
    statusByte[usb_app_pkg::ST_EXTPLL] = extPllActive;
    statusByte[usb_app_pkg::ST_FULL] = fullSpeed;
    statusByte[usb_app_pkg::ST_TEST] = loopbackActive;
  end

  reg_file_mem regFile (
    .mclk(mclk),
    .ce(ce),
    .we(access && wrRdSel && regfHit),
    .addr(registerSelectBus[usb_app_pkg::REGF_AW-1:0]),
    .wdata(hostWriteBus),
    .rdata(regfData)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      strobePrev_r <= 1'b1;
    end else if (ce) begin
      strobePrev_r <= dataStrobeN;
    end
  end

  // Host read sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdKind_r <= usb_app_pkg::RD_IDLE;
      rdFifo_r <= usb_app_pkg::SEL_RST;
      rcvSel <= usb_app_pkg::SEL_RST;
      rcvRdPtr <= usb_app_pkg::PTR_RST;
    end else if (ce) begin
      rdKind_r <= usb_app_pkg::RD_IDLE;
      if (access && !wrRdSel) begin
        if (regfHit) begin
          rdKind_r <= usb_app_pkg::RD_REGF;
        end else if (rxHit[3]) begin
          rdKind_r <= usb_app_pkg::RD_FIFO;
          rdFifo_r <= rxHit[2:0];
          rcvSel <= rxHit[2:0];
          rcvRdPtr <= rxRp_r[rxHit[2:0]];
        end else if (registerSelectBus == usb_app_pkg::STAT_ADDR) begin
          rdKind_r <= usb_app_pkg::RD_STAT;
        end else begin
          rdKind_r <= usb_app_pkg::RD_IDLE;
        end
      end
    end
  end

  // Read data stay until the next read; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      hostReadBus <= usb_app_pkg::DATA_RST;
    end else if (ce) begin
      case (rdKind_r)
        usb_app_pkg::RD_REGF: hostReadBus <= regfData;
        usb_app_pkg::RD_FIFO: hostReadBus <= rcvOutData;
        usb_app_pkg::RD_STAT: hostReadBus <= statusByte;
        default: begin
          if (access && !wrRdSel) begin
            hostReadBus <= (registerSelectBus == usb_app_pkg::PKT_ADDR) ?
                           {4'h0, pktRdy} : usb_app_pkg::DATA_RST;
          end
        end
      endcase
    end
  end

  // Host writes into the transmit RAMs
  always_ff @(posedge mclk) begin
    if (rst) begin
      trxWrb <= usb_app_pkg::WRB_IDLE;
      trxWrPtr <= usb_app_pkg::PTR_RST;
      trxInData <= usb_app_pkg::DATA_RST;
    end else if (ce) begin
      trxWrb <= usb_app_pkg::WRB_IDLE;
      if (access && wrRdSel && txHit[3]) begin
        trxWrb <= ~(7'h01 << txHit[2:0]);
        trxWrPtr <= txWp_r[txHit[2:0]];
        trxInData <= hostWriteBus;
      end
    end
  end

  // Serial engine reads from the transmit RAMs
  always_ff @(posedge mclk) begin
    if (rst) begin
      trxSel <= usb_app_pkg::SEL_RST;
      trxRdPtr <= usb_app_pkg::PTR_RST;
      txPend_r <= 1'b0;
      txFifo_r <= usb_app_pkg::SEL_RST;
      txLast_r <= 1'b0;
      txByte <= usb_app_pkg::DATA_RST;
      txByteValid <= 1'b0;
    end else if (ce) begin
      txPend_r <= txReq.req;
      txByteValid <= txPend_r;
      if (txReq.req) begin
        trxSel <= txReq.fifo;
        trxRdPtr <= txRp_r[txReq.fifo];
        txFifo_r <= txReq.fifo;
        txLast_r <= txReq.last;
      end
      if (txPend_r) begin
        txByte <= trxOutData;
      end
    end
  end

  // Receive RAM writes from the serial side or the loopback path
  always_ff @(posedge mclk) begin
    if (rst) begin
      rcvWrb <= usb_app_pkg::WRB_IDLE;
      rcvWrPtr <= usb_app_pkg::PTR_RST;
      rcvInData <= usb_app_pkg::DATA_RST;
    end else if (ce) begin
      rcvWrb <= usb_app_pkg::WRB_IDLE;
      if (rxSrc.valid && rxSrc.fifo != 3'h7) begin
        rcvWrb <= ~(7'h01 << rxSrc.fifo);
        rcvWrPtr <= rxWp_r[rxSrc.fifo];
        rcvInData <= rxSrc.data;
      end
    end
  end

  // Per-RAM pointers; pointers wrap at the 9-bit address space
  genvar gi;
  generate
    for (gi = 0; gi < usb_app_pkg::FIFO_NUM; gi++) begin : gPtr
      always_ff @(posedge mclk) begin
        if (rst) begin
          txWp_r[gi] <= usb_app_pkg::PTR_RST;
          txRp_r[gi] <= usb_app_pkg::PTR_RST;
          rxWp_r[gi] <= usb_app_pkg::PTR_RST;
          rxRp_r[gi] <= usb_app_pkg::PTR_RST;
        end else if (ce) begin
          if (access && wrRdSel && txHit[3] && txHit[2:0] == 3'(gi)) begin
            txWp_r[gi] <= txWp_r[gi] + 9'h001;
          end
          if (txReq.req && txReq.fifo == 3'(gi)) begin
            txRp_r[gi] <= txRp_r[gi] + 9'h001;
          end
          if (rxSrc.valid && rxSrc.fifo == 3'(gi)) begin
            rxWp_r[gi] <= rxWp_r[gi] + 9'h001;
          end
          if (hostFifoPop && rdFifo_r == 3'(gi)) begin
            rxRp_r[gi] <= rxRp_r[gi] + 9'h001;
          end
        end
      end
    end

    // Ready on a completed packet, dropped once the host drains it
    for (gi = 0; gi < usb_app_pkg::PKT_NUM; gi++) begin : gPkt
      always_ff @(posedge mclk) begin
        if (rst) begin
          pktRdy[gi] <= 1'b0;
        end else if (ce) begin
          if (rxSrc.valid && rxSrc.last && rxSrc.fifo == 3'(gi)) begin
            pktRdy[gi] <= 1'b1;
          end else if (hostFifoPop && rdFifo_r == 3'(gi) &&
                       rxRp_r[gi] + 9'h001 == rxWp_r[gi]) begin
            pktRdy[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // SETUP byte counting; any incoming SETUP byte wins over the host's clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      setupCnt_r <= 4'h0;
      setupRdy <= 1'b0;
    end else if (ce) begin
      if (rxSrc.valid && rxSrc.setup) begin
        if (setupCnt_r + 4'h1 == usb_app_pkg::SETUP_LEN) begin
          setupCnt_r <= 4'h0;
          setupRdy <= 1'b1;
        end else begin
          setupCnt_r <= setupCnt_r + 4'h1;
        end
      end else if (hostFifoPop && rdFifo_r == 3'h0) begin
        setupRdy <= 1'b0;
      end
    end
  end

  // Sticky until the status byte is read; a new error wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      isoErr <= 1'b0;
    end else if (ce) begin
      if (rxSrc.valid && rxSrc.iso && rxSrc.data1) begin
        isoErr <= 1'b1;
      end else if (rdKind_r == usb_app_pkg::RD_STAT) begin
        isoErr <= 1'b0;
      end
    end
  end

  // Pulse length follows the selected bus speed
  always_ff @(posedge mclk) begin
    if (rst) begin
      sofCnt_r <= usb_app_pkg::PTR_RST;
      validSof <= 1'b0;
    end else if (ce) begin
      if (sofDetect) begin
        sofCnt_r <= fullSpeed ? usb_app_pkg::SOF_FS_CYC : usb_app_pkg::SOF_LS_CYC;
      end else if (sofCnt_r != usb_app_pkg::PTR_RST) begin
        sofCnt_r <= sofCnt_r - 9'h001;
      end
      validSof <= sofDetect || (sofCnt_r > 9'h001);
    end
  end

  // Mode flags registered; each follows its input one cycle later
  always_ff @(posedge mclk) begin
    if (rst) begin
      usbReset <= 1'b0;
      extPllActive <= 1'b0;
      loopbackActive <= 1'b0;
    end else if (ce) begin
      usbReset <= usbResetIn;
      extPllActive <= extPllSelIn;
      loopbackActive <= testMode;
    end
  end

endmodule

/* usb_app_pkg.sv */
// Purpose: Shared constants and types for the application FIFO port
// Assumes: One 250 MHz clock, all port inputs synchronous to it
// Notes: Addresses at 0x80 and above are port decode, below are register file
package usb_app_pkg;

  // Register select decode
  localparam logic [7:0] TX_BASE = 8'h80;
  localparam logic [7:0] RX_BASE = 8'h88;
  localparam logic [7:0] STAT_ADDR = 8'h90;
  localparam logic [7:0] PKT_ADDR = 8'h91;
  localparam logic [7:0] FIFO_NUM8 = 8'h07;

  // Structure sizes
  localparam int FIFO_NUM = 7;
  localparam int PKT_NUM = 4;
  localparam int PTR_W = 9;
  localparam int REGF_AW = 7;
  localparam int REGF_DEPTH = 128;

  // Reset values
  localparam logic [8:0] PTR_RST = 9'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [6:0] WRB_IDLE = 7'h7F;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [3:0] PKT_RST = 4'h0;

  // Status byte fields
  localparam int ST_SETUP = 0;
  localparam int ST_ISO = 1;
  localparam int ST_USBRST = 2;
  localparam int ST_EXTPLL = 3;
  localparam int ST_FULL = 4;
  localparam int ST_TEST = 5;

  // SETUP sequence length in bytes
  localparam logic [3:0] SETUP_LEN = 4'h8;

  // Frame-start pulse: two bit times, counted at the mclk rate
  localparam int SOF_BITS = 2;
  localparam int FS_BIT_PS = 83333;
  localparam int LS_BIT_PS = 666667;
  localparam int MCLK_PS = 4000;
  localparam logic [8:0] SOF_FS_CYC = 9'((SOF_BITS * FS_BIT_PS) / MCLK_PS);
  localparam logic [8:0] SOF_LS_CYC = 9'((SOF_BITS * LS_BIT_PS) / MCLK_PS);

  // Byte arriving from the serial engine side toward a receive RAM
  typedef struct packed {
    logic valid;
    logic [2:0] fifo;
    logic [7:0] data;
    logic last;
    logic setup;
    logic iso;
    logic data1;
  } rx_byte_t;

  // Serial engine request for the next transmit byte
  typedef struct packed {
    logic req;
    logic [2:0] fifo;
    logic last;
  } tx_req_t;

  // Pending host read source
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_REGF = 2'b01,
    RD_FIFO = 2'b11,
    RD_STAT = 2'b10
  } rd_kind_t;

endpackage

/* reg_file_mem.sv */
// Purpose: Register file storage for the application port
// Assumes: Single port, write and read in the same cycle return old data
// Notes: Read data come out of a register
`timescale 1ns/100ps
module reg_file_mem (
  // Clocking
  input wire logic mclk,
  input wire logic ce,
  // Access
  input wire logic we,
  input wire logic [usb_app_pkg::REGF_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [usb_app_pkg::REGF_DEPTH];

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule

/* usb_app_fifo_port_asserts.sv */
// Purpose: Port-level checks for usb_app_fifo_port
// Assumes: ce held high by the bench
// Notes: Bound from tb
`timescale 1ns/100ps
module usb_app_fifo_port_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sysReset,
  // Host port
  input wire logic wrRdSel,
  input wire logic [7:0] registerSelectBus,
  input wire logic [7:0] hostWriteBus,
  input wire logic dataStrobeN,
  input wire logic [7:0] hostReadBus,
  // Modes and status
  input wire logic fullSpeed,
  input wire logic testMode,
  input wire logic extPllSelIn,
  input wire logic usbResetIn,
  input wire logic extPllActive,
  input wire logic usbReset,
  input wire logic loopbackActive,
  input wire logic [3:0] pktRdy,
  input wire logic isoErr,
  input wire logic validSof,
  // Engine side
  input wire logic sofDetect,
  input wire usb_app_pkg::rx_byte_t rxIn,
  input wire usb_app_pkg::tx_req_t txReq,
  input wire logic [7:0] txByte,
  input wire logic txByteValid,
  // RAMs
  input wire logic [7:0] trxOutData,
  input wire logic [7:0] trxInData,
  input wire logic [2:0] trxSel,
  input wire logic [6:0] trxWrb,
  input wire logic [7:0] rcvOutData,
  input wire logic [7:0] rcvInData,
  input wire logic [2:0] rcvSel,
  input wire logic [6:0] rcvWrb
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst || sysReset);
  logic [8:0] sofCnt_r;
  // Length of the current frame-start pulse
  always_ff @(posedge mclk) begin
    if (!nrst || sysReset || !validSof) begin
      sofCnt_r <= 9'h000;
    end else begin
      sofCnt_r <= sofCnt_r + 9'h001;
    end
  end
  AST_TXWR: assert property (
    $fell(dataStrobeN) && wrRdSel && registerSelectBus[7:3] == 5'h10
    && registerSelectBus[2:0] != 3'h7
    |=> trxWrb == ~(7'h01 << $past(registerSelectBus[2:0]))
    && trxInData == $past(hostWriteBus)) else $error("tx write strobe or data wrong");
  AST_WRB1: assert property (
    trxWrb != 7'h7F |-> $onehot(~trxWrb) ##1 trxWrb == 7'h7F)
    else $error("tx write strobe not one single cycle");
  AST_RXWR: assert property (
    rxIn.valid && rxIn.fifo != 3'h7 && !testMode && !loopbackActive
    |=> rcvWrb == ~(7'h01 << $past(rxIn.fifo)) && rcvInData == $past(rxIn.data))
    else $error("rx write strobe or data wrong");
  AST_RXRD: assert property (
    $fell(dataStrobeN) && !wrRdSel && registerSelectBus[7:3] == 5'h11
    && registerSelectBus[2:0] != 3'h7
    |=> rcvSel == $past(registerSelectBus[2:0]) ##1 hostReadBus == $past(rcvOutData))
    else $error("rx read select or data wrong");
  AST_TXRD: assert property (
    txReq.req |=> trxSel == $past(txReq.fifo) ##1 txByteValid && txByte == $past(trxOutData))
    else $error("tx read select or byte wrong");
  AST_PKT: assert property (
    rxIn.valid && rxIn.last && !rxIn.fifo[2] && !testMode && !loopbackActive
    |=> pktRdy[$past(rxIn.fifo[1:0])]) else $error("packet ready not set");
  AST_ISO: assert property (
    rxIn.valid && rxIn.iso && rxIn.data1 && !testMode && !loopbackActive |=> isoErr)
    else $error("iso error not set");
  AST_SOFGO: assert property (
    sofDetect |=> validSof) else $error("frame start pulse missing");
  // Speed may already change in the cycle the pulse ends
  AST_SOFLEN: assert property (
    $fell(validSof) && $past(nrst) && !$past(sysReset)
    |-> sofCnt_r == ($past(fullSpeed) ? usb_app_pkg::SOF_FS_CYC : usb_app_pkg::SOF_LS_CYC))
    else $error("frame start pulse length wrong");
  AST_MODE: assert property (
    $past(nrst) && !$past(sysReset) |-> extPllActive == $past(extPllSelIn)
    && loopbackActive == $past(testMode) && usbReset == $past(usbResetIn))
    else $error("mode copy wrong");
  cover property ($fell(dataStrobeN) && wrRdSel);
  cover property ($fell(validSof));
  cover property (txByteValid && loopbackActive);
endmodule

/* fifo_ram_model.sv */
// Purpose: Seven transmit and seven receive RAMs
// Assumes: Synchronous write, asynchronous read
// Notes: The missing eighth RAM returns the inverted write data
`timescale 1ns/100ps
module fifo_ram_model (
  // Clock
  input wire logic mclk,
  // Transmit RAMs
  input wire logic [7:0] trxInData,
  input wire logic [2:0] trxSel,
  input wire logic [8:0] trxWrPtr,
  input wire logic [8:0] trxRdPtr,
  input wire logic [6:0] trxWrb,
  output logic [7:0] trxOutData,
  // Receive RAMs
  input wire logic [7:0] rcvInData,
  input wire logic [2:0] rcvSel,
  input wire logic [8:0] rcvWrPtr,
  input wire logic [8:0] rcvRdPtr,
  input wire logic [6:0] rcvWrb,
  output logic [7:0] rcvOutData
);
  logic [7:0] txMem [7][512];
  logic [7:0] rxMem [7][512];
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 7; i++) begin
      if (!trxWrb[i]) begin
        txMem[i][trxWrPtr] <= trxInData;
      end
      if (!rcvWrb[i]) begin
        rxMem[i][rcvWrPtr] <= rcvInData;
      end
    end
  end
  assign trxOutData = (trxSel == 3'h7) ? ~trxInData : txMem[trxSel][trxRdPtr];
  assign rcvOutData = (rcvSel == 3'h7) ? ~rcvInData : rxMem[rcvSel][rcvRdPtr];
endmodule

/* tb.sv */
// Purpose: Self-checking bench for usb_app_fifo_port
// Assumes: Inputs change 1 ns after the rising edge
// Notes: ce is held high throughout
`timescale 1ns/100ps
module tb;
  logic mclk = 1'b0, nrst = 1'b0, sysReset = 1'b0, wrRdSel = 1'b0, dataStrobeN = 1'b1;
  logic fullSpeed = 1'b1, extPllSelIn = 1'b0, testMode = 1'b0, sofDetect = 1'b0;
  logic usbResetIn = 1'b0;
  logic [7:0] registerSelectBus = 8'h00, hostWriteBus = 8'h00;
  usb_app_pkg::rx_byte_t rxIn = '0;
  usb_app_pkg::tx_req_t txReq = '0;
  logic [7:0] hostReadBus, txByte, trxOutData, trxInData, rcvOutData, rcvInData;
  logic [3:0] pktRdy;
  logic setupRdy, isoErr, validSof, usbReset, extPllActive, loopbackActive, txByteValid;
  logic [2:0] trxSel, rcvSel;
  logic [8:0] trxWrPtr, trxRdPtr, rcvWrPtr, rcvRdPtr;
  logic [6:0] trxWrb, rcvWrb;
  int err_total = 0, check_count = 0, cycles = 0;
  // Clock at the full 250 MHz mclk rate
  initial begin
    forever #2 mclk = ~mclk;
  end
  usb_app_fifo_port i_usb_app_fifo_port (.mclk, .nrst, .ce(1'b1), .sysReset, .wrRdSel,
    .registerSelectBus, .hostWriteBus, .dataStrobeN, .hostReadBus, .fullSpeed,
    .extPllSelIn, .testMode, .pktRdy, .setupRdy, .isoErr, .validSof, .usbReset,
    .extPllActive, .loopbackActive, .rxIn, .txReq, .sofDetect, .usbResetIn, .txByte,
    .txByteValid, .trxOutData, .trxInData, .trxSel, .trxWrPtr, .trxRdPtr, .trxWrb,
    .rcvOutData, .rcvInData, .rcvSel, .rcvWrPtr, .rcvRdPtr, .rcvWrb);
  fifo_ram_model i_fifo_ram_model (.mclk, .trxInData, .trxSel, .trxWrPtr, .trxRdPtr,
    .trxWrb, .trxOutData, .rcvInData, .rcvSel, .rcvWrPtr, .rcvRdPtr, .rcvWrb, .rcvOutData);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Strobe held through the answer edge, so the bus never moves under it
  task automatic host(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    wrRdSel = wr;
    registerSelectBus = a;
    hostWriteBus = d;
    dataStrobeN = 1'b0;
    tick(2);
    q = hostReadBus;
    dataStrobeN = 1'b1;
    tick();
  endtask
  // Flags are last, setup, iso, data1
  task automatic rx(input logic [2:0] f, input logic [7:0] d, input logic [3:0] flg);
    rxIn = {1'b1, f, d, flg};
    tick();
    rxIn = '0;
    tick();
  endtask
  task automatic t_reset();
    chk("trxWrb", 9'h07F, 9'(trxWrb));
    chk("rcvWrb", 9'h07F, 9'(rcvWrb));
    chk("pktRdy", 9'h000, 9'(pktRdy));
    $display("test reset done");
  endtask
  task automatic t_regfile();
    logic [7:0] q;
    host(1'b1, 8'h00, 8'h5A, q);
    host(1'b1, 8'h7F, 8'hC3, q);
    host(1'b0, 8'h00, 8'h00, q);
    chk("reg 00", 9'h05A, 9'(q));
    host(1'b0, 8'h7F, 8'h00, q);
    chk("reg 7F", 9'h0C3, 9'(q));
    host(1'b0, 8'h92, 8'h00, q);
    chk("unmapped", 9'h000, 9'(q));
    $display("test regfile done");
  endtask
  task automatic t_tx();
    logic [7:0] q;
    for (int i = 0; i < 7; i++) host(1'b1, 8'h80 + 8'(i), 8'h10 + 8'(i), q);
    for (int i = 0; i < 7; i++) begin
      txReq = {1'b1, 3'(i), 1'b0};
      tick();
      txReq = '0;
      // Valid is a one-cycle pulse, two edges after the request
      tick();
      chk("txByteValid", 9'h001, 9'(txByteValid));
      chk("txByte", 9'h010 + 9'(i), 9'(txByte));
    end
    $display("test tx done");
  endtask
  task automatic t_rx();
    logic [7:0] q;
    for (int i = 0; i < 4; i++) rx(3'(i), 8'h40 + 8'(i), 4'h8);
    chk("pktRdy all", 9'h00F, 9'(pktRdy));
    host(1'b0, 8'h91, 8'h00, q);
    chk("pkt byte", 9'h00F, 9'(q));
    for (int j = 0; j < 8; j++) begin
      rx(3'h4, 8'(j), 4'h4);
      chk("setupRdy", 9'(j == 7), 9'(setupRdy));
    end
    for (int i = 0; i < 4; i++) begin
      host(1'b0, 8'h88 + 8'(i), 8'h00, q);
      chk("rx byte", 9'h040 + 9'(i), 9'(q));
      chk("pktRdy pop", 9'(4'(4'hF << (i + 1))), 9'(pktRdy));
    end
    chk("setupRdy clear", 9'h000, 9'(setupRdy));
    $display("test rx done");
  endtask
  task automatic t_iso();
    logic [7:0] q;
    rx(3'h5, 8'hEE, 4'h3);
    chk("isoErr", 9'h001, 9'(isoErr));
    host(1'b0, 8'h90, 8'h00, q);
    chk("status", 9'h012, 9'(q));
    chk("isoErr clear", 9'h000, 9'(isoErr));
    $display("test iso done");
  endtask
  task automatic sof_len(input logic fs, input logic [8:0] exp);
    int n;
    n = 0;
    fullSpeed = fs;
    sofDetect = 1'b1;
    tick();
    sofDetect = 1'b0;
    while (validSof === 1'b1 && n < 400) begin
      tick();
      n++;
    end
    chk("sof length", exp, 9'(n));
    $display("test sof done");
  endtask
  task automatic t_mode();
    logic [7:0] q;
    extPllSelIn = 1'b1;
    usbResetIn = 1'b1;
    testMode = 1'b1;
    tick(2);
    chk("extPllActive", 9'h001, 9'(extPllActive));
    chk("usbReset", 9'h001, 9'(usbReset));
    chk("loopbackActive", 9'h001, 9'(loopbackActive));
    host(1'b1, 8'h82, 8'h77, q);
    txReq = {1'b1, 3'h2, 1'b1};
    tick();
    txReq = '0;
    tick(4);
    chk("loop pktRdy", 9'h004, 9'(pktRdy));
    testMode = 1'b0;
    extPllSelIn = 1'b0;
    usbResetIn = 1'b0;
    tick(2);
    host(1'b0, 8'h8A, 8'h00, q);
    chk("loop byte", 9'h077, 9'(q));
    sysReset = 1'b1;
    tick();
    sysReset = 1'b0;
    chk("read after reset", 9'h000, 9'(hostReadBus));
    $display("test mode done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_regfile();
    t_tx();
    t_rx();
    t_iso();
    sof_len(1'b1, usb_app_pkg::SOF_FS_CYC);
    sof_len(1'b0, usb_app_pkg::SOF_LS_CYC);
    t_mode();
    print_verdict();
  end
endmodule
bind usb_app_fifo_port usb_app_fifo_port_asserts i_usb_app_fifo_port_asserts (.mclk, .nrst,
  .sysReset, .wrRdSel, .registerSelectBus, .hostWriteBus, .dataStrobeN, .hostReadBus,
  .fullSpeed, .testMode, .extPllSelIn, .usbResetIn, .extPllActive, .usbReset,
  .loopbackActive, .pktRdy, .isoErr, .validSof, .sofDetect, .rxIn, .txReq, .txByte,
  .txByteValid, .trxOutData, .trxInData, .trxSel, .trxWrb, .rcvOutData, .rcvInData,
  .rcvSel, .rcvWrb);
